/* File: rtl/pll_lock_event_monitor.sv */
// pll lock status, sticky events and loss-of-lock counter
// assumes analog detector outputs arrive asynchronously; register port on SYS_CLK
//
// Overview of operation
// - status bit 0 shows live lock indication
// - status bit 2 shows live rail-high condition
// - status bit 1 shows live rail-low condition
// - rail-high sets sticky event bit 2
// - rail-low sets sticky event bit 1
// - locked-to-unlocked edge sets event bit 0
// - write one clears flag; reserved bits zero
// - count lock deassertions, saturate at fifteen
// - single-shot mode holds lock once asserted
`timescale 1ns/10ps
`default_nettype none
`include "pll_lock_defs.svh"

module pll_lock_event_monitor (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOCK_RAW,
    input wire logic RAIL_HIGH_RAW,
    input wire logic RAIL_LOW_RAW,
    input wire logic SINGLE_SHOT_LOCK_SELECT,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [`PLL_REG_ADDR_W-1:0] REG_ADDR,
    input wire logic [`PLL_REG_DATA_W-1:0] REG_WDATA,
    output logic [`PLL_REG_DATA_W-1:0] REG_RDATA,
    output logic REG_RVALID,
    output logic LOCK_IND
);

    // saturating increment of the loss-of-lock counter
    function automatic logic [`PLL_CNT_W-1:0] sat_inc(input logic [`PLL_CNT_W-1:0] v);
        if (v == `PLL_CNT_MAX) begin
            sat_inc = v;
        end else begin
            sat_inc = v + `PLL_CNT_W'(1);
        end
    endfunction

    // raw detector bundle
    pll_lock_pkg::pll_ind_t raw_ind;
    // synchronised detector bundle
    pll_lock_pkg::pll_ind_t sync_ind;
    // write request bundle
    pll_lock_pkg::reg_wr_t wreq;

    // held lock for single-shot mode
    logic lock_held_r;
    // lock indication after mode selection
    logic lock_now;
    // previous lock indication, for edge detection
    logic lock_prev_r;
    // locked-to-unlocked edge
    logic lock_fall;
    // sticky event flags {rail_high, rail_low, loss_of_lock}
    logic [2:0] event_r;
    logic [2:0] event_nxt;
    // event sources this cycle
    logic [2:0] event_set;
    // write-one-to-clear mask this cycle
    logic [2:0] event_clr;
    // loss-of-lock counter
    logic [`PLL_CNT_W-1:0] unlock_cnt_r;
    logic [`PLL_CNT_W-1:0] unlock_cnt_nxt;
    // read data and valid
    logic [`PLL_REG_DATA_W-1:0] rdata_r;
    logic [`PLL_REG_DATA_W-1:0] rdata_nxt;
    logic rvalid_r;
    // status register image
    logic [`PLL_REG_DATA_W-1:0] status_img;

    assign raw_ind.lock = LOCK_RAW;
    assign raw_ind.rail_high = RAIL_HIGH_RAW;
    assign raw_ind.rail_low = RAIL_LOW_RAW;
    assign wreq.wr = REG_WR;
    assign wreq.addr = REG_ADDR;
    assign wreq.wdata = REG_WDATA;

    // detector outputs come from the analog side, so sync them first
    pin_sync u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .d_in(raw_ind),
        .q_out(sync_ind)
    );

    // single-shot hold: latches on first lock, released when mode is dropped
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lock_held_r <= 1'b0;
        end else if (!SINGLE_SHOT_LOCK_SELECT) begin
            lock_held_r <= 1'b0;
        end else if (sync_ind.lock) begin
            lock_held_r <= 1'b1;
        end
    end

    // in single-shot mode a later unlock is masked by the held value
    assign lock_now = sync_ind.lock | (SINGLE_SHOT_LOCK_SELECT & lock_held_r);

    // previous lock indication
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lock_prev_r <= 1'b0;
        end else begin
            lock_prev_r <= lock_now;
        end
    end

    // only a high-to-low transition counts, not a steady unlocked level
    assign lock_fall = lock_prev_r & ~lock_now;

    // event sources and clear mask
    always_comb begin
        event_set = 3'h0;
        event_set[`PLL_BIT_RAIL_HIGH] = sync_ind.rail_high;
        event_set[`PLL_BIT_RAIL_LOW] = sync_ind.rail_low;
        event_set[`PLL_BIT_LOCK] = lock_fall;
        event_clr = 3'h0;
        if (wreq.wr && wreq.addr == `PLL_REG_EVENT_IDX) begin
            // zeros in the write data leave flags alone
            event_clr = wreq.wdata[2:0];
        end
        // set after clear, so a coincident event survives the clear
        event_nxt = (event_r & ~event_clr) | event_set;
    end

    // sticky event flags
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            event_r <= `PLL_EVENT_RST;
        end else begin
            event_r <= event_nxt;
        end
    end

    // counter next value; a software write takes priority over an increment
    always_comb begin
        unlock_cnt_nxt = unlock_cnt_r;
        if (wreq.wr && wreq.addr == `PLL_REG_UNLOCK_CNT_IDX) begin
            // zero clears, any other value presets
            unlock_cnt_nxt = wreq.wdata[`PLL_CNT_W-1:0];
        end else if (lock_fall) begin
            unlock_cnt_nxt = sat_inc(unlock_cnt_r);
        end
    end

    // loss-of-lock counter
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            unlock_cnt_r <= `PLL_UNLOCK_CNT_RST;
        end else begin
            unlock_cnt_r <= unlock_cnt_nxt;
        end
    end

    // live status image, reserved bits zero
    always_comb begin
        status_img = `PLL_STATUS_RST;
        status_img[`PLL_BIT_LOCK] = lock_now;
        status_img[`PLL_BIT_RAIL_LOW] = sync_ind.rail_low;
        status_img[`PLL_BIT_RAIL_HIGH] = sync_ind.rail_high;
    end

    // read mux; unmapped index reads zero
    always_comb begin
        rdata_nxt = `PLL_UNMAPPED_RD;
        unique case (REG_ADDR)
            `PLL_REG_STATUS_IDX: rdata_nxt = status_img;
            `PLL_REG_EVENT_IDX: rdata_nxt = {5'h00, event_r};
            `PLL_REG_UNLOCK_CNT_IDX: rdata_nxt = {4'h0, unlock_cnt_r};
            default: rdata_nxt = `PLL_UNMAPPED_RD;
        endcase
    end

    // registered read data, held until the next read
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rdata_r <= `PLL_UNMAPPED_RD;
        end else if (REG_RD) begin
            rdata_r <= rdata_nxt;
        end
    end

    // one-cycle valid after each read strobe
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= REG_RD;
        end
    end

    assign REG_RDATA = rdata_r;
    assign REG_RVALID = rvalid_r;
    // lock indication to the rest of the device; combinational on sync flops
    assign LOCK_IND = lock_now;

endmodule

`default_nettype wire

/* File: include/pll_lock_defs.svh */
// constants for the pll lock status and event register block
// assumes inclusion by bare name from any file that needs the map
`ifndef PLL_LOCK_DEFS_SVH
`define PLL_LOCK_DEFS_SVH

// register index on the internal register port
`define PLL_REG_ADDR_W 2
`define PLL_REG_STATUS_IDX 2'h0
`define PLL_REG_EVENT_IDX 2'h1
`define PLL_REG_UNLOCK_CNT_IDX 2'h2

// register data width and reset values
`define PLL_REG_DATA_W 8
`define PLL_STATUS_RST 8'h00
`define PLL_EVENT_RST 3'h0
`define PLL_UNLOCK_CNT_RST 4'h0

// field positions shared by status and event registers
`define PLL_BIT_LOCK 0
`define PLL_BIT_RAIL_LOW 1
`define PLL_BIT_RAIL_HIGH 2

// loss-of-lock counter width and its ceiling
`define PLL_CNT_W 4
`define PLL_CNT_MAX 4'hf
`define PLL_CNT_ZERO 4'h0

// read data for an unmapped index
`define PLL_UNMAPPED_RD 8'h00

`endif

/* File: include/pll_lock_pkg.sv */
// types for the pll lock status and event register block
// assumes pll_lock_defs.svh is on the include path
`default_nettype none
`include "pll_lock_defs.svh"

package pll_lock_pkg;

    // one sample of the lock detector indications
    typedef struct packed {
        logic rail_high;
        logic rail_low;
        logic lock;
    } pll_ind_t;

    // write request on the register port
    typedef struct packed {
        logic wr;
        logic [`PLL_REG_ADDR_W-1:0] addr;
        logic [`PLL_REG_DATA_W-1:0] wdata;
    } reg_wr_t;

endpackage

`default_nettype wire

/* File: rtl/pin_sync.sv */
// two flip-flop level synchroniser for a bundle of indications
// assumes the inputs are asynchronous to clk and change slowly
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
    input wire logic clk,
    input wire logic rst,
    input wire pll_lock_pkg::pll_ind_t d_in,
    output pll_lock_pkg::pll_ind_t q_out
);

    // first stage: read only by the second stage
    pll_lock_pkg::pll_ind_t meta_r;
    // second stage: safe for logic
    pll_lock_pkg::pll_ind_t stable_r;

    // both stages clear at reset, so indications read low until sampled
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            stable_r <= '0;
        end else begin
            meta_r <= d_in;
            stable_r <= meta_r;
        end
    end

    assign q_out = stable_r;

endmodule

`default_nettype wire

/* File: verif/pll_lock_monitor_properties.sv */
// port assertions for the pll lock status and event block
// assumes one clock, SYS_CLK, and a bind onto the design top
`timescale 1ns/10ps
`default_nettype none
module pll_lock_monitor_properties (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOCK_RAW,
    input wire logic RAIL_HIGH_RAW,
    input wire logic RAIL_LOW_RAW,
    input wire logic SINGLE_SHOT_LOCK_SELECT,
    input wire logic REG_RD,
    input wire logic [1:0] REG_ADDR,
    input wire logic [7:0] REG_RDATA,
    input wire logic REG_RVALID,
    input wire logic LOCK_IND
);
    logic [1:0] up_r; // edges since reset, stops at 3
    // sync flops need three clean edges before pins and status agree
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            up_r <= 2'h0;
        end else if (up_r != 2'h3) begin
            up_r <= up_r + 2'h1;
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    // a read taken once the syncs are flushed
    sequence rd_at(a);
        up_r == 2'h3 && REG_RD && REG_ADDR == a;
    endsequence
    AST_RD_VALID: assert property (REG_RD |=> REG_RVALID)
        else $error("read answer missing");
    AST_STATUS_LIVE: assert property (
        ($stable({LOCK_RAW, RAIL_HIGH_RAW, RAIL_LOW_RAW}) && !SINGLE_SHOT_LOCK_SELECT)[*3]
        ##0 rd_at(2'h0) |=> REG_RDATA ==
        {5'h00, $past(RAIL_HIGH_RAW), $past(RAIL_LOW_RAW), $past(LOCK_RAW)})
        else $error("status differs from pins");
    AST_LOCK_LIVE: assert property (
        (!SINGLE_SHOT_LOCK_SELECT && $stable(LOCK_RAW))[*3] ##0 up_r == 2'h3
        |-> LOCK_IND == LOCK_RAW) else $error("lock output differs from pin");
    AST_SINGLE_HOLD: assert property (
        SINGLE_SHOT_LOCK_SELECT && LOCK_IND ##1 SINGLE_SHOT_LOCK_SELECT |-> LOCK_IND)
        else $error("held lock dropped");
    AST_RAIL_HIGH_EVT: assert property (
        RAIL_HIGH_RAW[*4] ##0 rd_at(2'h1) |=> REG_RDATA[2]) else $error("rail high event lost");
    AST_RAIL_LOW_EVT: assert property (
        RAIL_LOW_RAW[*4] ##0 rd_at(2'h1) |=> REG_RDATA[1]) else $error("rail low event lost");
    AST_LOL_EVT: assert property (
        $fell(LOCK_IND) ##1 rd_at(2'h1) |=> REG_RDATA[0]) else $error("unlock event lost");
    AST_RESERVED_ZERO: assert property (REG_RD |=> REG_RDATA[7:4] == 4'h0 &&
        ($past(REG_ADDR) == 2'h2 || !REG_RDATA[3])) else $error("reserved bits set");
endmodule
bind pll_lock_event_monitor pll_lock_monitor_properties i_pll_lock_monitor_properties (
    .SYS_CLK(SYS_CLK), .RST(RST), .LOCK_RAW(LOCK_RAW), .RAIL_HIGH_RAW(RAIL_HIGH_RAW),
    .RAIL_LOW_RAW(RAIL_LOW_RAW), .SINGLE_SHOT_LOCK_SELECT(SINGLE_SHOT_LOCK_SELECT),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_RDATA(REG_RDATA),
    .REG_RVALID(REG_RVALID), .LOCK_IND(LOCK_IND));
`default_nettype wire

/* File: verif/tb_top.sv */
// directed bench for the pll lock status and event block
// assumes inputs change on the falling edge, sync latency of two edges
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0, rst = 1, lk = 0, rh = 0, rl = 0, ss = 0, wr = 0, rd = 0;
    logic [1:0] ad = 2'h0; // register index
    logic [7:0] wd = 8'h00, rdat;
    logic rv, li;
    int err_count = 0, n_tests = 0;
    pll_lock_event_monitor i_pll_lock_event_monitor (.SYS_CLK(clk), .RST(rst), .LOCK_RAW(lk),
        .RAIL_HIGH_RAW(rh), .RAIL_LOW_RAW(rl), .SINGLE_SHOT_LOCK_SELECT(ss), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(ad), .REG_WDATA(wd), .REG_RDATA(rdat), .REG_RVALID(rv),
        .LOCK_IND(li));
    // 100 ns period
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, ex, got);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // one-cycle write strobe
    task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = 1'b1; ad = a; wd = d;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // answer lands one edge after the strobe
    task automatic rd_reg(input logic [1:0] a, input logic [7:0] ex, input string nm);
        @(negedge clk);
        rd = 1'b1; ad = a;
        @(negedge clk);
        rd = 1'b0;
        chk("rvalid", 8'h01, {7'h00, rv});
        chk(nm, ex, rdat);
    endtask
    task automatic t_reset();
        rd_reg(2'h0, 8'h00, "status");
        rd_reg(2'h1, 8'h00, "events");
        rd_reg(2'h2, 8'h00, "count");
        wr_reg(2'h0, 8'hff);
        rd_reg(2'h0, 8'h00, "status ro");
        rd_reg(2'h3, 8'h00, "unmapped");
    endtask
    task automatic t_live();
        lk = 1'b1; rh = 1'b1;
        cyc(3);
        rd_reg(2'h0, 8'h05, "status high");
        chk("lock out", 8'h01, {7'h00, li});
        rh = 1'b0; rl = 1'b1;
        cyc(3);
        rd_reg(2'h0, 8'h03, "status low");
        rd_reg(2'h1, 8'h06, "low event live");
        rl = 1'b0;
        cyc(3);
        rd_reg(2'h1, 8'h06, "rail events");
        wr_reg(2'h1, 8'hf8);
        rd_reg(2'h1, 8'h06, "zero write");
        wr_reg(2'h1, 8'h06);
        rd_reg(2'h1, 8'h00, "w1c");
        rh = 1'b1; // clear while still railed must not stick
        cyc(3);
        wr_reg(2'h1, 8'h04);
        rd_reg(2'h1, 8'h04, "set beats clear");
        rh = 1'b0;
        cyc(3);
        // one-cycle pulse: its set edge is the edge that takes the clear
        rh = 1'b1;
        cyc(1);
        rh = 1'b0;
        wr_reg(2'h1, 8'h04);
        rd_reg(2'h1, 8'h04, "pulse beats clear");
    endtask
    task automatic t_loss();
        wr_reg(2'h2, 8'h0e);
        lk = 1'b0;
        // read taken one edge after the lock output falls
        cyc(2);
        rd_reg(2'h1, 8'h05, "unlock event");
        rd_reg(2'h2, 8'h0f, "preset count");
        lk = 1'b1;
        cyc(3);
        lk = 1'b0;
        cyc(4);
        rd_reg(2'h2, 8'h0f, "saturate");
        wr_reg(2'h2, 8'h00);
        rd_reg(2'h2, 8'h00, "clear count");
    endtask
    task automatic t_single();
        lk = 1'b1; ss = 1'b1;
        cyc(3);
        lk = 1'b0;
        cyc(4);
        chk("held lock", 8'h01, {7'h00, li});
        rd_reg(2'h2, 8'h00, "no count held");
        ss = 1'b0; // release exposes the unlock
        cyc(4);
        chk("released", 8'h00, {7'h00, li});
        rd_reg(2'h2, 8'h01, "count released");
    endtask
    task automatic results();
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        cyc(2);
        rst = 1'b0;
        t_reset();
        t_live();
        t_loss();
        t_single();
        results();
    end
endmodule
`default_nettype wire
